// File: inc/min_fan_start_temp_interval_pkg.sv
package min_fan_start_temp_interval_pkg;
    // ==========================================
    // field layout of the shared cycle register and the dynamic control bit
    localparam int          LOCAL_CODE_LSB    = 3;
    localparam int          REMOTE2_LO_LSB    = 6;
    localparam int          REMOTE2_MSB_BIT   = 0;
    localparam int          CODE_W            = 3;
    localparam int          COUNT_W           = 12;
    localparam logic [7:0]  CYCLE_REG_RESET   = 8'h00;
    localparam logic [7:0]  DYN_CTRL_RESET    = 8'h00;
    // ==========================================
    // base intervals in monitoring cycles
    localparam logic [COUNT_W-1:0] DEC_BASE_CYCLES = 12'h008;
    localparam logic [COUNT_W-1:0] INC_BASE_CYCLES = 12'h010;

    typedef enum logic {
        DIR_DECREASE,
        DIR_INCREASE
    } adjust_dir_t;

    // one channel's adjustment request and direction
    typedef struct packed {
        logic        adjust_req;
        adjust_dir_t dir;
    } adjust_req_t;

    typedef struct packed {
        logic dec_ready;
        logic inc_ready;
    } adjust_ready_t;
endpackage : min_fan_start_temp_interval_pkg

// File: sim/min_fan_start_temp_adjust_interval_timer_test.sv
`timescale 1ns/1ps
module min_fan_start_temp_adjust_interval_timer_test;
    import min_fan_start_temp_interval_pkg::*;
    typedef struct {int ch; logic dir; logic [2:0] code; int lim;} row_t;
    logic          clk_i, nrst_i, cycle_wr_i, dyn_wr_i, dyn_wdata_i, monitor_done_i;
    logic [7:0]    cycle_wdata_i, cycle_rdata_o;
    logic          dyn_rdata_o, local_adjust_o, remote2_adjust_o;
    adjust_req_t   local_req_i, remote2_req_i;
    adjust_ready_t local_ready_o, remote2_ready_o;
    int            bad_count = 0, num_checks = 0, grants = 0, g0;
    row_t          rows[20];
    min_fan_start_temp_adjust_interval_timer DUT (.clk_i(clk_i), .nrst_i(nrst_i), .cycle_wr_i(cycle_wr_i),
        .cycle_wdata_i(cycle_wdata_i), .dyn_wr_i(dyn_wr_i), .dyn_wdata_i(dyn_wdata_i),
        .monitor_done_i(monitor_done_i), .local_req_i(local_req_i),
        .remote2_req_i(remote2_req_i), .cycle_rdata_o(cycle_rdata_o),
        .dyn_rdata_o(dyn_rdata_o), .local_ready_o(local_ready_o),
        .remote2_ready_o(remote2_ready_o), .local_adjust_o(local_adjust_o),
        .remote2_adjust_o(remote2_adjust_o));
    // ==========================================
    // helpers
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step
    task automatic pulse(input int n);
        repeat (n) begin
            monitor_done_i = 1'b1;
            step(1);
            monitor_done_i = 1'b0;
            step(1);
        end
    endtask : pulse
    task automatic wr(input logic [7:0] data, input logic msb);
        cycle_wdata_i = data;
        dyn_wdata_i = msb;
        {cycle_wr_i, dyn_wr_i} = 2'b11;
        step(1);
        {cycle_wr_i, dyn_wr_i} = 2'b00;
        step(1);
    endtask : wr
    task automatic run_row(input row_t r);
        adjust_req_t   q;
        adjust_ready_t rd;
        int            k;
        q = '{1'b1, adjust_dir_t'(r.dir)};
        if (r.ch == 0) wr({2'b00, r.code, 3'h0}, 1'b0);
        else wr({r.code[1:0], 6'h00}, r.code[2]);
        check("code", {dyn_rdata_o, cycle_rdata_o},
              r.ch ? {r.code, 6'h00} : {3'h0, r.code, 3'h0});
        if (r.ch == 0) local_req_i = q;
        else remote2_req_i = q;
        // first grant restarts the count from a known point
        g0 = grants;
        k = 0;
        while (grants == g0 && k < 2100) begin
            pulse(1);
            step(3);
            k++;
        end
        check("first grant", {11'h000, k < 2100}, 12'h001);
        g0 = grants;
        pulse(r.lim - 1);
        step(3);
        rd = r.ch ? remote2_ready_o : local_ready_o;
        check("early grant", grants - g0, 12'h000);
        check("ready", rd, r.dir ? 12'h002 : 12'h000);
        pulse(1);
        rd = r.ch ? remote2_ready_o : local_ready_o;
        check("adjust", {local_adjust_o, remote2_adjust_o}, r.ch ? 12'h001 : 12'h002);
        check("ready clear", rd, 12'h000);
        step(3);
        check("grant", grants - g0, 12'h001);
        local_req_i = '0;
        remote2_req_i = '0;
    endtask : run_row
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up
    // ==========================================
    // clock, grant tally, watchdog
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) grants <= grants + int'(local_adjust_o | remote2_adjust_o);
    initial begin
        #400000;
        bad_count++;
        wrap_up();
    end
    // ==========================================
    // main sequence
    initial begin
        nrst_i = 1'b0;
        {cycle_wr_i, dyn_wr_i, dyn_wdata_i, monitor_done_i} = 4'h0;
        cycle_wdata_i = 8'h00;
        local_req_i = '0;
        remote2_req_i = '0;
        for (int i = 0; i < 16; i++) rows[i] = '{0, i[0], i[3:1], (8 << i[3:1]) << i[0]};
        rows[16] = '{1, 1'b0, 3'h4, 128};
        rows[17] = '{1, 1'b1, 3'h3, 128};
        rows[18] = '{1, 1'b0, 3'h1, 16};
        rows[19] = '{1, 1'b1, 3'h6, 1024};
        step(16);
        nrst_i = 1'b1;
        check("reset", {local_ready_o, remote2_ready_o, cycle_rdata_o}, 12'h000);
        wr(8'hff, 1'b1);
        check("full write", {dyn_rdata_o, cycle_rdata_o}, 12'h1ff);
        foreach (rows[i]) run_row(rows[i]);
        // reset in mid-run clears the codes
        nrst_i = 1'b0;
        step(1);
        check("mid reset", {dyn_rdata_o, cycle_rdata_o}, 12'h000);
        check("mid ready", {local_ready_o, remote2_ready_o}, 12'h000);
        // count must start from zero again after reset
        nrst_i = 1'b1;
        local_req_i = '{1'b1, DIR_DECREASE};
        g0 = grants;
        pulse(7);
        step(3);
        check("restart wait", grants - g0, 12'h000);
        pulse(1);
        check("restart grant", {local_adjust_o, remote2_adjust_o}, 12'h002);
        step(3);
        local_req_i = '0;
        wrap_up();
    end
endmodule : min_fan_start_temp_adjust_interval_timer_test

// File: src/min_fan_start_temp_adjust_interval_timer.sv
`timescale 1ns/1ps
module min_fan_start_temp_adjust_interval_timer (
    input  wire logic                             clk_i,
    input  wire logic                             nrst_i,
    input  wire logic                             cycle_wr_i,
    input  wire logic [7:0]                       cycle_wdata_i,
    input  wire logic                             dyn_wr_i,
    input  wire logic                             dyn_wdata_i,
    input  wire logic                             monitor_done_i,
    input  wire min_fan_start_temp_interval_pkg::adjust_req_t   local_req_i,
    input  wire min_fan_start_temp_interval_pkg::adjust_req_t   remote2_req_i,
    output logic      [7:0]                       cycle_rdata_o,
    output logic                                  dyn_rdata_o,
    output min_fan_start_temp_interval_pkg::adjust_ready_t      local_ready_o,
    output min_fan_start_temp_interval_pkg::adjust_ready_t      remote2_ready_o,
    output logic                                  local_adjust_o,
    output logic                                  remote2_adjust_o
);
    import min_fan_start_temp_interval_pkg::*;

    // ==========================================
    // configuration registers
    logic [7:0]        cycle_reg;
    logic              dyn_msb_reg;
    logic [CODE_W-1:0] local_adjust_interval_code;
    logic [CODE_W-1:0] remote2_adjust_interval_code;

    assign local_adjust_interval_code   = cycle_reg[LOCAL_CODE_LSB +: CODE_W];
    assign remote2_adjust_interval_code = {dyn_msb_reg,
                                           cycle_reg[REMOTE2_LO_LSB +: 2]};

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cycle_reg   <= CYCLE_REG_RESET;
            dyn_msb_reg <= DYN_CTRL_RESET[REMOTE2_MSB_BIT];
        end else begin
            if (cycle_wr_i) begin
                cycle_reg <= cycle_wdata_i;
            end
            if (dyn_wr_i) begin
                dyn_msb_reg <= dyn_wdata_i;
            end
        end
    end

    // ==========================================
    // read back of the written codes
    logic [7:0] cycle_rdata_next;
    logic       dyn_rdata_next;

    assign cycle_rdata_next = cycle_wr_i ? cycle_wdata_i : cycle_reg;
    assign dyn_rdata_next   = dyn_wr_i ? dyn_wdata_i : dyn_msb_reg;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cycle_rdata_o <= CYCLE_REG_RESET;
            dyn_rdata_o   <= DYN_CTRL_RESET[REMOTE2_MSB_BIT];
        end else begin
            cycle_rdata_o <= cycle_rdata_next;
            dyn_rdata_o   <= dyn_rdata_next;
        end
    end

    // ==========================================
    // per channel interval timers
    min_fan_start_temp_channel_timer u_local (
        .clk_i          (clk_i),
        .nrst_i         (nrst_i),
        .code_i         (local_adjust_interval_code),
        .monitor_done_i (monitor_done_i),
        .req_i          (local_req_i),
        .ready_o        (local_ready_o),
        .adjust_o       (local_adjust_o)
    );

    min_fan_start_temp_channel_timer u_remote2 (
        .clk_i          (clk_i),
        .nrst_i         (nrst_i),
        .code_i         (remote2_adjust_interval_code),
        .monitor_done_i (monitor_done_i),
        .req_i          (remote2_req_i),
        .ready_o        (remote2_ready_o),
        .adjust_o       (remote2_adjust_o)
    );

    // ==========================================
    // checks
    a_remote2_code_join: assert property (@(posedge clk_i) disable iff (!nrst_i)
        dyn_wr_i |=> remote2_adjust_interval_code[2] == $past(dyn_wdata_i))
        else $error("remote 2 code msb not taken from control bit");

    a_local_code_field: assert property (@(posedge clk_i) disable iff (!nrst_i)
        cycle_wr_i |=> local_adjust_interval_code ==
                       $past(cycle_wdata_i[LOCAL_CODE_LSB +: CODE_W]))
        else $error("local code field not written");

    a_remote2_low_bits: assert property (@(posedge clk_i) disable iff (!nrst_i)
        cycle_wr_i |=> remote2_adjust_interval_code[1:0] ==
                       $past(cycle_wdata_i[REMOTE2_LO_LSB +: 2]))
        else $error("remote 2 low bits not written");

    a_cycle_readback: assert property (@(posedge clk_i) disable iff (!nrst_i)
        cycle_wr_i |=> cycle_rdata_o == $past(cycle_wdata_i))
        else $error("cycle register read back wrong");

    a_dyn_readback: assert property (@(posedge clk_i) disable iff (!nrst_i)
        dyn_wr_i |=> dyn_rdata_o == $past(dyn_wdata_i))
        else $error("control bit read back wrong");

    a_codes_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !cycle_wr_i && !dyn_wr_i |=> $stable(local_adjust_interval_code)
                                      && $stable(remote2_adjust_interval_code))
        else $error("interval code changed without a write");

endmodule : min_fan_start_temp_adjust_interval_timer

// ==========================================
// one channel's interval counter
module min_fan_start_temp_channel_timer (
    input  wire logic                             clk_i,
    input  wire logic                             nrst_i,
    input  wire logic [2:0]                       code_i,
    input  wire logic                             monitor_done_i,
    input  wire min_fan_start_temp_interval_pkg::adjust_req_t   req_i,
    output min_fan_start_temp_interval_pkg::adjust_ready_t      ready_o,
    output logic                                  adjust_o
);
    import min_fan_start_temp_interval_pkg::*;

    logic [COUNT_W-1:0] elapsed_reg;
    logic [COUNT_W-1:0] elapsed_next;
    logic [COUNT_W-1:0] dec_limit;
    logic [COUNT_W-1:0] inc_limit;
    logic               dec_ok;
    logic               inc_ok;
    logic               grant;
    logic               dec_ready_next;
    logic               inc_ready_next;

    // ==========================================
    // interval limits and grant
    assign dec_limit = DEC_BASE_CYCLES << code_i;
    assign inc_limit = INC_BASE_CYCLES << code_i;
    assign dec_ok    = elapsed_reg >= dec_limit;
    assign inc_ok    = elapsed_reg >= inc_limit;
    assign grant     = req_i.adjust_req &&
                       ((req_i.dir == DIR_DECREASE) ? dec_ok : inc_ok);

    // saturate at the all-ones top of the count so readiness never wraps away
    assign elapsed_next = grant ? '0 :
                          (monitor_done_i && elapsed_reg != '1) ?
                          elapsed_reg + 12'h001 : elapsed_reg;

    assign dec_ready_next = elapsed_next >= dec_limit;
    assign inc_ready_next = elapsed_next >= inc_limit;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            elapsed_reg <= '0;
            ready_o     <= '0;
            adjust_o    <= 1'b0;
        end else begin
            elapsed_reg       <= elapsed_next;
            ready_o.dec_ready <= dec_ready_next;
            ready_o.inc_ready <= inc_ready_next;
            adjust_o          <= grant;
        end
    end

    // ==========================================
    // checks
    sequence s_adjust_pulse;
        adjust_o ##1 !adjust_o;
    endsequence

    a_grant_restarts: assert property (@(posedge clk_i) disable iff (!nrst_i)
        grant |=> elapsed_reg == '0 && adjust_o)
        else $error("count not restarted after adjustment");

    a_dec_waits: assert property (@(posedge clk_i) disable iff (!nrst_i)
        grant && req_i.dir == DIR_DECREASE |-> elapsed_reg >= (DEC_BASE_CYCLES << code_i))
        else $error("decrease made before interval");

    a_inc_waits: assert property (@(posedge clk_i) disable iff (!nrst_i)
        grant && req_i.dir == DIR_INCREASE |-> elapsed_reg >= (INC_BASE_CYCLES << code_i))
        else $error("increase made before interval");

    a_count_monitor: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !monitor_done_i && !grant |=> $stable(elapsed_reg))
        else $error("count moved without monitoring cycle");

    a_no_early_grant: assert property (@(posedge clk_i) disable iff (!nrst_i)
        grant |=> (!grant)[*8])
        else $error("adjustment without elapsed monitoring cycles");

    a_adjust_one_cycle: assert property (@(posedge clk_i) disable iff (!nrst_i)
        grant |=> s_adjust_pulse)
        else $error("adjust pulse not a single cycle");

    a_ready_cleared: assert property (@(posedge clk_i) disable iff (!nrst_i)
        grant |=> ready_o == '0)
        else $error("readiness left set after adjustment");

    a_count_steps: assert property (@(posedge clk_i) disable iff (!nrst_i)
        monitor_done_i && !grant && elapsed_reg != '1 |=> elapsed_reg == $past(elapsed_reg) + 12'h001)
        else $error("monitoring cycle not counted");

    a_count_saturates: assert property (@(posedge clk_i) disable iff (!nrst_i)
        elapsed_reg == '1 && !grant |=> elapsed_reg == '1)
        else $error("count wrapped past its top");

    a_dec_before_inc: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ready_o.inc_ready |-> ready_o.dec_ready)
        else $error("increase ready before decrease ready");

    a_no_adjust_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !req_i.adjust_req |=> !adjust_o)
        else $error("adjustment made without request");

endmodule : min_fan_start_temp_channel_timer
